//--- pkg/bsme_pkg.sv
// shared constants, types and carriers of the bit, shift and move execution block
// Summary of operation
// - io bit force one, two cycles, no flags
// - io bit force zero, two cycles, no flags
// - shift left, zero in, update Z C N V
// - shift right, zero in, update Z C N V
// - rotate left through carry, update flags
// - rotate right through carry, update flags
// - signed right shift keeps bit seven
// - register bit copied into transfer flag
// - transfer flag copied into register bit
// - each status flag set or cleared alone
// - pointer pre decrement then load, two cycles
package bsme_pkg;

  // ----------------------------------------------------------------
  // datapath sizes
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;           // working register width
  localparam int RF_DEPTH = 32;        // number of working registers
  localparam int RF_AW = 5;            // working register index width
  localparam int IO_AW = 5;            // bit addressable io space
  localparam int PTR_W = 16;           // pointer pair width

  // ----------------------------------------------------------------
  // status flag bit positions
  // ----------------------------------------------------------------
  localparam int FLG_C = 0;            // carry
  localparam int FLG_Z = 1;            // zero
  localparam int FLG_N = 2;            // negative
  localparam int FLG_V = 3;            // overflow
  localparam int FLG_S = 4;            // signed
  localparam int FLG_H = 5;            // half carry
  localparam int FLG_T = 6;            // transfer
  localparam int FLG_I = 7;            // global interrupt enable
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // ----------------------------------------------------------------
  // pointer register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] X_LO_IDX = 5'h1A;
  localparam logic [4:0] X_HI_IDX = 5'h1B;
  localparam logic [4:0] Y_LO_IDX = 5'h1C;
  localparam logic [4:0] Y_HI_IDX = 5'h1D;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;   // enable control
  localparam logic [11:0] OFS_FLAGS = 12'h004;  // status flags, r/w
  localparam logic [11:0] OFS_PTRS = 12'h008;   // pointers, read only
  localparam logic [11:0] OFS_COUNT = 12'h00C;  // retired ops, read only
  localparam int CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // operation lengths in cycles
  // ----------------------------------------------------------------
  localparam int IO_OP_CYCLES = 2;
  localparam int LD_OP_CYCLES = 2;
  localparam int SIMPLE_OP_CYCLES = 1;

  // ----------------------------------------------------------------
  // operation codes from decode
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_IO_SET, OP_IO_CLR, OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_ASR,
    OP_SWAP, OP_FLAG_SET, OP_FLAG_CLR, OP_BST, OP_BLD, OP_MOV, OP_COPY_REGISTER_PAIR, OP_LDI,
    OP_LD_X, OP_LD_XP, OP_LD_XM, OP_LD_Y, OP_LD_YP, OP_LD_YM
  } bsme_opcode_e;

  typedef enum {ST_IDLE, ST_IO_WB, ST_LD_WB} bsme_state_e;

  // one decoded operation
  typedef struct packed {
    bsme_opcode_e code;                // what to do
    logic [RF_AW-1:0] rd;              // destination or tested register
    logic [RF_AW-1:0] rr;              // source register
    logic [2:0] bsel;                  // bit or flag index
    logic [DATA_W-1:0] imm;            // immediate constant
    logic [IO_AW-1:0] io_addr;         // io register address
  } bsme_op_s;

  // io register port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [IO_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bsme_io_s;

  // data memory read request
  typedef struct packed {
    logic rd;
    logic [PTR_W-1:0] addr;
  } bsme_mem_s;

  // shifter flag results
  typedef struct packed {
    logic c;
    logic z;
    logic n;
    logic v;
  } bsme_shflg_s;

endpackage

//--- logic/bsme_shifter.sv
// combinational shift and rotate unit with its flag results
`timescale 1ns/10ps
`default_nettype none

module bsme_shifter
  import bsme_pkg::*;
(
  input wire bsme_opcode_e code,            // shift kind
  input wire logic [DATA_W-1:0] din,        // operand
  input wire logic cin,                     // old carry
  output logic [DATA_W-1:0] dout,           // result
  output bsme_shflg_s flg                   // new c z n v
);

  // ----------------------------------------------------------------
  // result and carry out
  // ----------------------------------------------------------------
  always_comb begin
    dout = din;
    flg.c = cin;
    case (code)
      OP_SHL: begin
        dout = {din[DATA_W-2:0], 1'b0};
        flg.c = din[DATA_W-1];
      end
      OP_SHR: begin
        dout = {1'b0, din[DATA_W-1:1]};
        flg.c = din[0];
      end
      OP_ROL: begin
        dout = {din[DATA_W-2:0], cin};
        flg.c = din[DATA_W-1];
      end
      OP_ROR: begin
        dout = {cin, din[DATA_W-1:1]};
        flg.c = din[0];
      end
      OP_ASR: begin
        dout = {din[DATA_W-1], din[DATA_W-1:1]};
        flg.c = din[0];
      end
      default: begin
        dout = din;
        flg.c = cin;
      end
    endcase
    // common flags from the result
    flg.n = dout[DATA_W-1];
    flg.z = (dout == '0);
    flg.v = flg.n ^ flg.c;
  end

endmodule

`default_nettype wire

//--- logic/bsme_exec.sv
// execution datapath for bit, shift, flag and move operations with apb view
`timescale 1ns/10ps
`default_nettype none

module bsme_exec
  import bsme_pkg::*;
(
  input wire logic pclk,                    // core clock
  input wire logic presetn,                 // async reset, low active
  // apb slave
  input wire logic psel,                    // apb select
  input wire logic penable,                 // apb access phase
  input wire logic pwrite,                  // apb direction
  input wire logic [11:0] paddr,            // apb byte address
  input wire logic [31:0] pwdata,           // apb write data
  output logic [31:0] prdata,               // apb read data
  output logic pready,                      // apb ready
  output logic pslverr,                     // apb error
  // decode side
  input wire logic op_valid,                // operation offered
  input wire bsme_op_s op,                  // decoded operation
  output logic op_ready,                    // operation taken
  // io register port
  output bsme_io_s io_req,                  // io read or write
  input wire logic [DATA_W-1:0] io_rdata,   // io read data, same cycle
  // data memory port
  output bsme_mem_s mem_req,                // data memory read
  input wire logic [DATA_W-1:0] mem_rdata,  // memory data, same cycle
  // core view
  input wire logic [RF_AW-1:0] peek_addr,   // register to observe
  output logic [DATA_W-1:0] peek_data,      // observed register
  output logic [7:0] status_flags           // current flags
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // bank, flags and staging flops
  bsme_state_e state_q, state_d;            // sequencer
  logic [DATA_W-1:0] rf_q [RF_DEPTH];       // working registers
  logic [DATA_W-1:0] rf_d [RF_DEPTH];
  logic [7:0] flags_q, flags_d;             // status flags
  bsme_io_s io_q, io_d;                     // io request flops
  bsme_mem_s mem_q, mem_d;                  // memory request flops
  logic set_q, set_d;                       // io op forces one
  logic [2:0] bit_q, bit_d;                 // io bit under change
  logic [RF_AW-1:0] ldst_q, ldst_d;         // load destination
  logic ldy_q, ldy_d;                       // load uses the y pointer
  logic [PTR_W-1:0] ptr_q, ptr_d;           // pointer value to write back
  logic [31:0] ctrl_q, ctrl_d;              // control register
  logic [31:0] count_q, count_d;            // retired operations
  logic [31:0] prdata_q, prdata_d;          // apb read data
  logic perr_q, perr_d;                     // apb error flag
  logic [DATA_W-1:0] peek_q, peek_d;        // observed register

  // combinational helpers
  logic accept;                             // operation taken this cycle
  logic [DATA_W-1:0] sh_out;                // shifter result
  bsme_shflg_s sh_flg;                      // shifter flags

  // ----------------------------------------------------------------
  // shift unit
  // ----------------------------------------------------------------
  // reads the operand register
  bsme_shifter u_shifter (
    .code (op.code),
    .din  (rf_q[op.rd]),
    .cin  (flags_q[FLG_C]),
    .dout (sh_out),
    .flg  (sh_flg)
  );

  // ----------------------------------------------------------------
  // handshake and outputs
  // ----------------------------------------------------------------
  // ready only when idle and enabled by software
  assign op_ready = (state_q == ST_IDLE) && ctrl_q[CTRL_EN_BIT];
  assign accept = op_valid && op_ready;
  // the bus never stalls
  assign pready = 1'b1;                     // zero wait states
  assign prdata = prdata_q;
  assign pslverr = perr_q;
  // requests leave from flops
  assign io_req = io_q;
  assign mem_req = mem_q;
  assign peek_data = peek_q;
  assign status_flags = flags_q;

  // ----------------------------------------------------------------
  // apb registers: next values
  // ----------------------------------------------------------------
  always_comb begin
    prdata_d = prdata_q;
    perr_d = 1'b0;
    ctrl_d = ctrl_q;
    // setup phase decodes and stages the read answer
    if (psel && !penable) begin
      prdata_d = 32'h0000_0000;
      // unmapped reads give zero
      case (paddr)
        OFS_CTRL: prdata_d = ctrl_q;
        OFS_FLAGS: prdata_d = {24'h00_0000, flags_q};
        OFS_PTRS: prdata_d = {rf_q[Y_HI_IDX], rf_q[Y_LO_IDX], rf_q[X_HI_IDX], rf_q[X_LO_IDX]};
        OFS_COUNT: prdata_d = count_q;
        default: perr_d = 1'b1;             // unmapped address
      endcase
    end
    // access phase keeps the error visible
    if (psel && penable) begin
      perr_d = perr_q;
    end
    // writes land on the access edge
    if (psel && penable && pwrite && (paddr == OFS_CTRL)) begin
      ctrl_d = {31'h0000_0000, pwdata[CTRL_EN_BIT]};
    end
  end

  // ----------------------------------------------------------------
  // execution: next values
  // ----------------------------------------------------------------
  always_comb begin
    logic [PTR_W-1:0] ptr;                  // selected pointer
    logic [RF_AW-1:0] pair;                 // even pair index
    ptr = '0;
    pair = '0;
    state_d = state_q;
    rf_d = rf_q;
    flags_d = flags_q;
    io_d = '0;                              // requests are one cycle pulses
    mem_d = '0;
    set_d = set_q;
    bit_d = bit_q;
    ldst_d = ldst_q;
    ldy_d = ldy_q;
    ptr_d = ptr_q;
    count_d = count_q;
    peek_d = rf_q[peek_addr];
    // software overwrite of the flags, execution wins below
    if (psel && penable && pwrite && (paddr == OFS_FLAGS)) begin
      flags_d = pwdata[7:0];
    end
    // idle takes ops, others finish
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          case (op.code)
            // read now, write back next
            OP_IO_SET, OP_IO_CLR: begin
              io_d.rd = 1'b1;               // read phase of read-modify-write
              io_d.addr = op.io_addr;
              set_d = (op.code == OP_IO_SET);
              bit_d = op.bsel;
              state_d = ST_IO_WB;
            end
            // shared shifter
            OP_SHL, OP_SHR, OP_ROL, OP_ROR, OP_ASR: begin
              rf_d[op.rd] = sh_out;
              flags_d[FLG_C] = sh_flg.c;
              flags_d[FLG_Z] = sh_flg.z;
              flags_d[FLG_N] = sh_flg.n;
              flags_d[FLG_V] = sh_flg.v;
            end
            // flags untouched
            OP_SWAP: begin
              rf_d[op.rd] = {rf_q[op.rd][3:0], rf_q[op.rd][7:4]};
            end
            // one flag by index
            OP_FLAG_SET: begin
              flags_d[op.bsel] = 1'b1;
            end
            OP_FLAG_CLR: begin
              flags_d[op.bsel] = 1'b0;
            end
            // register bit to flag
            OP_BST: begin
              flags_d[FLG_T] = rf_q[op.rd][op.bsel];
            end
            // flag to register bit
            OP_BLD: begin
              rf_d[op.rd][op.bsel] = flags_q[FLG_T];
            end
            // byte copy
            OP_MOV: begin
              rf_d[op.rd] = rf_q[op.rr];
            end
            // even pairs only
            OP_COPY_REGISTER_PAIR: begin
              pair = {op.rr[RF_AW-1:1], 1'b0};
              rf_d[{op.rd[RF_AW-1:1], 1'b0}] = rf_q[pair];
              rf_d[{op.rd[RF_AW-1:1], 1'b1}] = rf_q[{pair[RF_AW-1:1], 1'b1}];
            end
            // constant from the op
            OP_LDI: begin
              rf_d[op.rd] = op.imm;
            end
            // pointer update waits
            OP_LD_X, OP_LD_XP, OP_LD_XM, OP_LD_Y, OP_LD_YP, OP_LD_YM: begin
              ldy_d = (op.code == OP_LD_Y) || (op.code == OP_LD_YP) || (op.code == OP_LD_YM);
              ptr = ldy_d ? {rf_q[Y_HI_IDX], rf_q[Y_LO_IDX]} : {rf_q[X_HI_IDX], rf_q[X_LO_IDX]};
              mem_d.rd = 1'b1;
              if ((op.code == OP_LD_XM) || (op.code == OP_LD_YM)) begin
                ptr_d = ptr - 16'h0001;
                mem_d.addr = ptr_d;
              end else if ((op.code == OP_LD_XP) || (op.code == OP_LD_YP)) begin
                ptr_d = ptr + 16'h0001;
                mem_d.addr = ptr;
              end else begin
                ptr_d = ptr;                // plain indirect
                mem_d.addr = ptr;
              end
              ldst_d = op.rd;
              state_d = ST_LD_WB;
            end
            // nop only retires
            default: begin
              // no operation
            end
          endcase
          // single cycle kinds retire on the accept edge
          if (!(state_d inside {ST_IO_WB, ST_LD_WB})) begin
            count_d = count_q + 32'h0000_0001;
          end
        end
      end
      // io write back
      ST_IO_WB: begin
        // write back with only the chosen bit changed
        io_d.wr = 1'b1;
        io_d.addr = io_q.addr;
        if (set_q) begin
          io_d.wdata = io_rdata | (8'h01 << bit_q);
        end else begin
          io_d.wdata = io_rdata & ~(8'h01 << bit_q);
        end
        count_d = count_q + 32'h0000_0001;
        state_d = ST_IDLE;
      end
      // load write back
      ST_LD_WB: begin
        // pointer first, so a destination inside the pointer holds the data
        if (ldy_q) begin
          rf_d[Y_LO_IDX] = ptr_q[7:0];
          rf_d[Y_HI_IDX] = ptr_q[15:8];
        end else begin
          rf_d[X_LO_IDX] = ptr_q[7:0];
          rf_d[X_HI_IDX] = ptr_q[15:8];
        end
        rf_d[ldst_q] = mem_rdata;
        count_d = count_q + 32'h0000_0001;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // all flops of the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      for (int i = 0; i < RF_DEPTH; i++) begin
        rf_q[i] <= '0;
      end
      flags_q <= FLAGS_RST;
      io_q <= '0;
      mem_q <= '0;
      set_q <= 1'b0;
      bit_q <= 3'h0;
      ldst_q <= '0;
      ldy_q <= 1'b0;
      ptr_q <= 16'h0000;
      ctrl_q <= CTRL_RST;
      count_q <= COUNT_RST;
      prdata_q <= 32'h0000_0000;
      perr_q <= 1'b0;
      peek_q <= '0;
    end else begin
      state_q <= state_d;
      rf_q <= rf_d;
      flags_q <= flags_d;
      io_q <= io_d;
      mem_q <= mem_d;
      set_q <= set_d;
      bit_q <= bit_d;
      ldst_q <= ldst_d;
      ldy_q <= ldy_d;
      ptr_q <= ptr_d;
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      prdata_q <= prdata_d;
      perr_q <= perr_d;
      peek_q <= peek_d;
    end
  end

endmodule

`default_nettype wire

//--- verif/bsme_far_model.sv
// io register space and data memory facing the execution block
`timescale 1ns/10ps
`default_nettype none
module bsme_far_model
  import bsme_pkg::*;
(
  input wire logic pclk,                  // clock
  input wire logic presetn,               // reset, low active
  input wire bsme_io_s io_req,            // io request
  output logic [DATA_W-1:0] io_rdata,     // io read data
  input wire bsme_mem_s mem_req,          // memory request
  output logic [DATA_W-1:0] mem_rdata     // memory read data
);
  logic [DATA_W-1:0] io_q [32];           // io registers
  logic [DATA_W-1:0] pat;                 // memory byte at the address
  assign pat = mem_req.addr[7:0] ^ mem_req.addr[15:8] ^ 8'h5A;
  // answer only while asked, otherwise an inverted value
  assign io_rdata = io_req.rd ? io_q[io_req.addr] : ~io_q[io_req.addr];
  assign mem_rdata = mem_req.rd ? pat : ~pat;
  // io register takes the write pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 32; i++)
        io_q[i] <= 8'(i) ^ 8'hA5;
    end else if (io_req.wr) begin
      io_q[io_req.addr] <= io_req.wdata;
    end
  end
endmodule
`default_nettype wire

//--- verif/bsme_exec_properties.sv
// concurrent checks on the ports of the execution block
`timescale 1ns/10ps
`default_nettype none
module bsme_exec_props
  import bsme_pkg::*;
(
  input wire logic pclk,                  // clock
  input wire logic presetn,               // reset, low active
  input wire logic psel,                  // apb select
  input wire logic penable,               // apb access
  input wire logic pwrite,                // apb direction
  input wire logic [11:0] paddr,          // apb address
  input wire logic [31:0] pwdata,         // apb write data
  input wire logic [31:0] prdata,         // apb read data
  input wire logic pready,                // apb ready
  input wire logic pslverr,               // apb error
  input wire logic op_valid,              // op offered
  input wire bsme_op_s op,                // decoded op
  input wire logic op_ready,              // op taken
  input wire bsme_io_s io_req,            // io request
  input wire logic [DATA_W-1:0] io_rdata, // io data
  input wire bsme_mem_s mem_req,          // memory request
  input wire logic [DATA_W-1:0] mem_rdata,// memory data
  input wire logic [RF_AW-1:0] peek_addr, // observed index
  input wire logic [DATA_W-1:0] peek_data,// observed value
  input wire logic [7:0] status_flags     // flags
);
  logic acc;                              // op accepted
  logic wrf;                              // apb write in access
  logic pk;                               // observed register is the operand
  assign acc = op_valid && op_ready;
  assign wrf = psel && penable && pwrite;
  assign pk = acc && peek_addr == op.rd && !wrf;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_io_set_bit: assert property (acc && op.code == OP_IO_SET |=> io_req.rd && io_req.addr == $past(op.io_addr)
    ##1 io_req.wr && io_req.wdata == ($past(io_rdata) | (8'h01 << $past(op.bsel, 2)))) else $error("io set bad");
  a_io_clr_bit: assert property (acc && op.code == OP_IO_CLR |=> io_req.rd
    ##1 io_req.wr && io_req.wdata == ($past(io_rdata) & ~(8'h01 << $past(op.bsel, 2)))) else $error("io clear bad");
  a_two_cycle_busy: assert property (acc && op.code inside {OP_IO_SET, OP_IO_CLR, [OP_LD_X:OP_LD_YM]}
    |=> !op_ready ##1 op_ready) else $error("busy length bad");
  a_flags_kept: assert property (acc && !wrf && op.code inside {OP_IO_SET, OP_IO_CLR, OP_SWAP, OP_BLD}
    |=> $stable(status_flags)) else $error("flags changed");
  a_shl_flags: assert property (pk && op.code == OP_SHL |=> status_flags[FLG_C] == peek_data[7] &&
    status_flags[FLG_Z] == (peek_data[6:0] == 7'h00) && status_flags[FLG_V] == (peek_data[6] ^ peek_data[7]))
    else $error("shift left flags bad");
  a_shr_flags: assert property (pk && op.code == OP_SHR |=> status_flags[FLG_C] == peek_data[0] &&
    !status_flags[FLG_N] && status_flags[FLG_Z] == (peek_data[7:1] == 7'h00)) else $error("shift right flags bad");
  a_rol_flags: assert property (pk && op.code == OP_ROL |=> status_flags[FLG_C] == peek_data[7] &&
    status_flags[FLG_Z] == ({peek_data[6:0], $past(status_flags[FLG_C])} == 8'h00)) else $error("rotate flags bad");
  a_asr_flags: assert property (pk && op.code == OP_ASR |=> status_flags[FLG_C] == peek_data[0] &&
    status_flags[FLG_N] == peek_data[7]) else $error("signed shift flags bad");
  a_bst_copy: assert property (pk && op.code == OP_BST |=> status_flags[FLG_T] == peek_data[$past(op.bsel)] &&
    status_flags[5:0] == $past(status_flags[5:0])) else $error("bit store bad");
  a_flag_set: assert property (acc && !wrf && op.code == OP_FLAG_SET
    |=> status_flags == ($past(status_flags) | (8'h01 << $past(op.bsel)))) else $error("flag set bad");
  c_io_set: cover property (acc && op.code == OP_IO_SET);
  c_ld_post: cover property (acc && op.code == OP_LD_XP);
  c_ror: cover property (acc && op.code == OP_ROR);
endmodule
bind bsme_exec bsme_exec_props chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .op_valid(op_valid), .op(op), .op_ready(op_ready), .io_req(io_req), .io_rdata(io_rdata), .mem_req(mem_req),
  .mem_rdata(mem_rdata), .peek_addr(peek_addr), .peek_data(peek_data), .status_flags(status_flags));
`default_nettype wire

//--- verif/tb.sv
// self checking bench for the execution block
`timescale 1ns/10ps
`default_nettype none
module tb
  import bsme_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, op_valid, op_ready, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] io_rdata, mem_rdata, peek_data, status_flags, ef, v;
  logic [8:0] x;
  logic [4:0] peek_addr;
  bsme_op_s op;
  bsme_io_s io_req;
  bsme_mem_s mem_req;
  bsme_opcode_e sc;
  int failures, comparisons, ops_n;
  bsme_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
    .op(op), .op_ready(op_ready), .io_req(io_req), .io_rdata(io_rdata), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .peek_addr(peek_addr), .peek_data(peek_data), .status_flags(status_flags));
  bsme_far_model far (.pclk(pclk), .presetn(presetn), .io_req(io_req), .io_rdata(io_rdata),
    .mem_req(mem_req), .mem_rdata(mem_rdata));
  // ----------------------------------------
  // clock
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task complete_run();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", s, e, g);
      failures++;
    end
  endtask
  // apb transfer, waits for ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      chk("apb wait", 1, 0);
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // wait until the block takes ops
  task wrdy();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (op_ready !== 1'b1 && n < 50);
    if (op_ready !== 1'b1) begin
      chk("op wait", 1, 0);
      complete_run();
    end
  endtask
  // offer one op and wait for its end
  task do_op(input bsme_opcode_e c, input logic [4:0] d, s, input logic [2:0] b, input logic [7:0] k);
    op <= '{code: c, rd: d, rr: s, bsel: b, imm: k, io_addr: s};
    op_valid <= 1'b1;
    wrdy();
    op_valid <= 1'b0;
    ops_n++;
    wrdy();
  endtask
  task chkreg(input logic [4:0] a, input logic [7:0] e);
    peek_addr <= a;
    @(posedge pclk);
    @(posedge pclk);
    chk("register", e, peek_data);
  endtask
  // expected {carry, result} of a shift
  function automatic logic [8:0] shx(input bsme_opcode_e c, input logic [7:0] d, input logic ci);
    case (c)
      OP_SHL: return {d, 1'b0};
      OP_SHR: return {d[0], 1'b0, d[7:1]};
      OP_ROL: return {d, ci};
      OP_ROR: return {d[0], ci, d[7:1]};
      default: return {d[0], d[7], d[7:1]};
    endcase
  endfunction
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, op_valid, paddr, pwdata, op, peek_addr} = '0;
    {failures, comparisons, ops_n} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_CTRL, '0);
    chk("ctrl", CTRL_RST, rd);
    apb(1'b0, OFS_COUNT, '0);
    chk("count", COUNT_RST, rd);
    apb(1'b1, OFS_PTRS, 32'hFFFF_FFFF);
    apb(1'b0, OFS_PTRS, '0);
    chk("ptrs", 32'h0, rd);
    apb(1'b0, 12'h010, '0);
    chk("slverr", 1, err);
    apb(1'b1, OFS_FLAGS, 32'h0000_00A5);
    ef = 8'hA5;
    chk("flags", ef, status_flags);
    for (int i = 0; i < 10; i++) begin
      sc = bsme_opcode_e'(OP_SHL + i / 2);
      v = (i % 2) ? 8'h01 : 8'h81;
      do_op(OP_LDI, 5'd16, '0, '0, v);
      do_op(bsme_opcode_e'(OP_FLAG_SET + i % 2), '0, '0, 3'(FLG_C), '0);
      ef[FLG_C] = !(i % 2);
      do_op(sc, 5'd16, '0, '0, '0);
      x = shx(sc, v, ef[FLG_C]);
      ef[3:0] = {x[7] ^ x[8], x[7], x[7:0] == 8'h00, x[8]};
      chkreg(5'd16, x[7:0]);
      chk("flags", ef, status_flags);
    end
    do_op(OP_LDI, 5'd17, '0, '0, 8'h3C);
    do_op(OP_SWAP, 5'd17, '0, '0, '0);
    chkreg(5'd17, 8'hC3);
    for (int i = 0; i < 16; i++) begin
      do_op(bsme_opcode_e'(OP_FLAG_SET + i / 8), '0, '0, 3'(i), '0);
      ef[i % 8] = (i < 8);
      chk("flags", ef, status_flags);
    end
    do_op(OP_BST, 5'd17, '0, 3'd1, '0);
    chk("flags", 8'h40, status_flags);
    do_op(OP_LDI, 5'd18, '0, '0, 8'h00);
    do_op(OP_BLD, 5'd18, '0, 3'd5, '0);
    chkreg(5'd18, 8'h20);
    do_op(OP_MOV, 5'd19, 5'd17, '0, '0);
    chkreg(5'd19, 8'hC3);
    do_op(OP_LDI, 5'd16, '0, '0, 8'h5E);
    do_op(OP_COPY_REGISTER_PAIR, 5'd20, 5'd16, '0, '0);
    chkreg(5'd20, 8'h5E);
    chkreg(5'd21, 8'hC3);
    do_op(OP_IO_SET, '0, 5'd5, 3'd3, '0);
    @(posedge pclk);
    chk("io", 8'hA8, far.io_q[5]);
    do_op(OP_IO_CLR, '0, 5'd5, 3'd7, '0);
    @(posedge pclk);
    chk("io", 8'h28, far.io_q[5]);
    chk("flags", 8'h40, status_flags);
    do_op(OP_LDI, 5'd26, '0, '0, 8'h10);
    do_op(OP_LDI, 5'd27, '0, '0, 8'h00);
    do_op(OP_LD_XP, 5'd1, '0, '0, '0);
    chkreg(5'd1, 8'h4A);
    do_op(OP_LDI, 5'd28, '0, '0, 8'h00);
    do_op(OP_LDI, 5'd29, '0, '0, 8'h01);
    do_op(OP_LD_YM, 5'd2, '0, '0, '0);
    chkreg(5'd2, 8'hA5);
    apb(1'b0, OFS_PTRS, '0);
    chk("ptrs", 32'h00FF_0011, rd);
    do_op(OP_LD_Y, 5'd3, '0, '0, '0);
    do_op(OP_LD_X, 5'd4, '0, '0, '0);
    do_op(OP_LD_XM, 5'd5, '0, '0, '0);
    do_op(OP_LD_YP, 5'd6, '0, '0, '0);
    do_op(OP_NOP, 5'd3, '0, '0, '0);
    chkreg(5'd3, 8'hA5);
    chkreg(5'd4, 8'h4B);
    chkreg(5'd5, 8'h4A);
    chkreg(5'd6, 8'hA5);
    apb(1'b0, OFS_PTRS, '0);
    chk("ptrs", 32'h0100_0010, rd);
    apb(1'b1, OFS_CTRL, '0);
    chk("op ready", 0, op_ready);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b0, OFS_COUNT, '0);
    chk("count", 32'(ops_n), rd);
    complete_run();
  end
endmodule
`default_nettype wire
